/* verif/nvmc_ctrl_tb_top.sv */
// self-checking bench for nvmc_ctrl: register access, read port, unlocked
// program/erase starts, refusals and reset; the bench plays the memory macro
// assumes the design files and nvmc_defines.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "nvmc_defines.svh"
module nvmc_ctrl_tb_top;
   // register row: offset, write value, readback, error response
   typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] x; logic err;} nvmc_row_t;
   // operation row: control byte, address low, unlock break kind, step count, steps
   typedef struct {logic [7:0] c; logic [7:0] al; int brk; int n;
      nvmc_pkg::nvmc_cmd_t s0; nvmc_pkg::nvmc_cmd_t s1;} nvmc_op_row_t;
   logic pclk = 1'b0; // bench clock
   logic presetn = 1'b0; // reset, active low
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
   logic [7:0] paddr = 8'h00; // apb address
   logic [31:0] pwdata = 32'h0; // apb write data
   logic [31:0] prdata, r; // read data, last taken
   logic pready, pslverr, e; // apb answer, last error taken
   logic mem_rd_en, mem_rd_cfg, mem_rd_prog, cpu_stall, rd_prog_seen, rd_cfg_seen;
   logic [`NVMC_ADDR_W-1:0] mem_rd_addr, rd_addr_seen; // read port address
   logic [`NVMC_DATA_W-1:0] mem_rdata; // macro read data
   nvmc_pkg::nvmc_mem_req_t mem_req, first_req; // step request, first step seen
   logic mem_done = 1'b0; // step answer
   logic ce = 1'b1; // clock enable, low freezes the design
   logic stall_seen = 1'b0; // stall seen during the last operation
   int dly = 0, dcnt = 0, fail_count = 0, tests_run = 0;
   nvmc_pkg::nvmc_cmd_t steps[$]; // steps answered, in order
   nvmc_row_t rows[8] = '{'{8'h08, 8'hff, 32'hff, 1'b0}, '{8'h0c, 8'h7f, 32'hff, 1'b0},
      '{8'h0c, 8'h00, 32'h80, 1'b0}, '{8'h10, 8'ha5, 32'ha5, 1'b0},
      '{8'h14, 8'hff, 32'h3f, 1'b0}, '{8'h04, 8'h55, 32'h00, 1'b0},
      '{8'h00, 8'hf4, 32'hf4, 1'b0}, '{8'h20, 8'h12, 32'h00, 1'b1}};
   nvmc_op_row_t ops[9] = '{
      '{8'h34, 8'h02, 0, 2, nvmc_pkg::NVMC_CMD_EE_ERASE, nvmc_pkg::NVMC_CMD_EE_WRITE},
      '{8'ha4, 8'h02, 0, 1, nvmc_pkg::NVMC_CMD_LATCH, nvmc_pkg::NVMC_CMD_NONE},
      '{8'h84, 8'h02, 0, 2, nvmc_pkg::NVMC_CMD_LATCH, nvmc_pkg::NVMC_CMD_PROGRAM},
      '{8'h94, 8'h02, 0, 1, nvmc_pkg::NVMC_CMD_ERASE, nvmc_pkg::NVMC_CMD_NONE},
      '{8'hc4, 8'h02, 0, 2, nvmc_pkg::NVMC_CMD_LATCH, nvmc_pkg::NVMC_CMD_PROGRAM},
      '{8'hc4, 8'h06, 0, 0, nvmc_pkg::NVMC_CMD_NONE, nvmc_pkg::NVMC_CMD_NONE},
      '{8'h80, 8'h02, 0, 0, nvmc_pkg::NVMC_CMD_NONE, nvmc_pkg::NVMC_CMD_NONE},
      '{8'h84, 8'h02, 1, 0, nvmc_pkg::NVMC_CMD_NONE, nvmc_pkg::NVMC_CMD_NONE},
      '{8'h84, 8'h02, 2, 0, nvmc_pkg::NVMC_CMD_NONE, nvmc_pkg::NVMC_CMD_NONE}};

   nvmc_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_rd_en(mem_rd_en), .mem_rd_cfg(mem_rd_cfg),
      .mem_rd_prog(mem_rd_prog), .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata),
      .mem_req(mem_req), .mem_done(mem_done), .cpu_stall(cpu_stall));

   // 250 MHz clock
   initial forever #2 pclk = ~pclk;
   // macro read data follows the address, so a wrong address shows
   assign mem_rdata = {~mem_rd_addr[5:0], mem_rd_addr[7:0]};
   // macro step port: answers each held step dly+1 cycles after it appears, logs steps
   always @(posedge pclk) begin
      if (mem_rd_en === 1'b1) begin
         rd_addr_seen <= mem_rd_addr;
         rd_prog_seen <= mem_rd_prog;
         rd_cfg_seen <= mem_rd_cfg;
      end
      if (cpu_stall === 1'b1) stall_seen <= 1'b1;
      if (mem_done && steps.size() == 0) first_req <= mem_req;
      if (mem_done) steps.push_back(mem_req.cmd);
      if (mem_req.cmd === nvmc_pkg::NVMC_CMD_NONE || mem_done) begin
         dcnt <= 0;
         mem_done <= 1'b0;
      end else begin
         dcnt <= dcnt + 1;
         mem_done <= (dcnt == dly);
      end
   end
   // hang guard, well above the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      end_of_test();
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      tests_run++;
      if (s !== x) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask
   // one apb transfer, entered just after a rising edge; holds until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 8'h00);
      chk(n, r, x);
   endtask
   // unlock (or break it), start, wait for the write bit to drop, check
   task automatic run_op(input nvmc_op_row_t o);
      logic [7:0] x;
      int k = 0;
      apb(1'b1, `NVMC_OFS_ADDR_LOW, o.al);
      apb(1'b1, `NVMC_OFS_CONTROL, o.c & 8'hfd);
      steps.delete();
      stall_seen <= 1'b0;
      if (o.brk != 1) apb(1'b1, `NVMC_OFS_UNLOCK, `NVMC_UNLOCK_FIRST);
      if (o.brk == 2) apb(1'b0, `NVMC_OFS_ADDR_LOW, 8'h00);
      if (o.brk != 1) apb(1'b1, `NVMC_OFS_UNLOCK, `NVMC_UNLOCK_SECOND);
      apb(1'b1, `NVMC_OFS_CONTROL, o.c | 8'h02);
      do begin
         apb(1'b0, `NVMC_OFS_CONTROL, 8'h00);
         k++;
      end while (r[1] !== 1'b0 && k < 100);
      // refused: error set, write bit low; done: error clear, erase bit cleared after an erase
      x = (o.n == 0) ? ((o.c | 8'h08) & 8'hfd) :
         (o.c & 8'hf5 & ((o.s0 == nvmc_pkg::NVMC_CMD_ERASE) ? 8'hef : 8'hff));
      chk("control after op", r, {24'h0, x});
      chk("step count", 32'(steps.size()),
         32'(o.n));
      if (o.n > 0) chk("first step", 32'(steps[0]),
         32'(o.s0));
      if (o.n > 1) chk("second step", 32'(steps[1]), 32'(o.s1));
      if (o.n > 0) chk("step address", 32'(first_req.addr), {24'h0, o.al});
      if (o.n > 0) chk("step data", 32'(first_req.wdata), 32'h2c5a);
      if (o.n > 0) chk("step space", 32'({first_req.prog_space, first_req.cfg_space}),
         32'(o.c[7:6]));
      chk("stall", {31'h0, stall_seen}, {31'h0, (o.n > 0) && (o.c[7] || o.c[6])});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`NVMC_OFS_CONTROL, 32'h00, "control reset");
      rd(`NVMC_OFS_ADDR_LOW, 32'h00, "address low reset");
      rd(`NVMC_OFS_ADDR_HIGH, 32'h80, "address high reset");
      // register rows: write, read back, error response
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].x, "register readback");
         chk("slave error", {31'h0, e}, {31'h0, rows[i].err});
      end
      $display("test registers done");
      // read port: flash word, config id word, config hole
      apb(1'b1, `NVMC_OFS_ADDR_HIGH, 8'h01);
      apb(1'b1, `NVMC_OFS_ADDR_LOW, 8'h3c);
      apb(1'b1, `NVMC_OFS_CONTROL, 8'h81);
      rd(`NVMC_OFS_CONTROL, 32'h80, "read bit cleared");
      rd(`NVMC_OFS_DATA_LOW, 32'h3c, "data low");
      rd(`NVMC_OFS_DATA_HIGH, 32'h03, "data high");
      chk("read flash select", {31'h0, rd_prog_seen}, 32'h1);
      chk("read address", 32'(rd_addr_seen), 32'h013c);
      apb(1'b1, `NVMC_OFS_ADDR_HIGH, 8'h00);
      apb(1'b1, `NVMC_OFS_ADDR_LOW, 8'h06);
      apb(1'b1, `NVMC_OFS_CONTROL, 8'h41);
      rd(`NVMC_OFS_DATA_HIGH, 32'h39, "config id high");
      chk("read config select", {31'h0, rd_cfg_seen}, 32'h1);
      apb(1'b1, `NVMC_OFS_ADDR_LOW, 8'h05);
      apb(1'b1, `NVMC_OFS_CONTROL, 8'h41);
      rd(`NVMC_OFS_DATA_LOW, 32'h00, "config hole low");
      rd(`NVMC_OFS_DATA_HIGH, 32'h00, "config hole high");
      // clock enable low freezes the block, so this write is lost
      ce <= 1'b0;
      apb(1'b1, `NVMC_OFS_ADDR_LOW, 8'h77);
      ce <= 1'b1;
      rd(`NVMC_OFS_ADDR_LOW, 32'h05, "frozen by clock enable");
      $display("test read port done");
      // operations, macro answering promptly then ever slower
      apb(1'b1, `NVMC_OFS_DATA_LOW, 8'h5a);
      apb(1'b1, `NVMC_OFS_DATA_HIGH, 8'h2c);
      foreach (ops[i]) begin
         dly = i * 2;
         run_op(ops[i]);
      end
      $display("test operations done");
      // reset in the middle of a slow eeprom write
      dly = 30;
      apb(1'b1, `NVMC_OFS_CONTROL, 8'h04);
      apb(1'b1, `NVMC_OFS_UNLOCK, `NVMC_UNLOCK_FIRST);
      apb(1'b1, `NVMC_OFS_UNLOCK, `NVMC_UNLOCK_SECOND);
      apb(1'b1, `NVMC_OFS_CONTROL, 8'h06);
      chk("busy step", 32'(mem_req.cmd), 32'(nvmc_pkg::NVMC_CMD_EE_ERASE));
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("step after reset", 32'(mem_req.cmd), 32'(nvmc_pkg::NVMC_CMD_NONE));
      rd(`NVMC_OFS_CONTROL, 32'h00, "control after reset");
      rd(`NVMC_OFS_ADDR_HIGH, 32'h80, "address high after reset");
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire

/* verilog/nvmc_ctrl.sv */
// nonvolatile memory control: apb register file, unlock check, read port
// and self-timed program/erase start for flash, config space and eeprom
// assumes a memory macro on pclk with a combinational read port and a
// step port that answers with mem_done; apb master on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "nvmc_defines.svh"
module nvmc_ctrl (
   input wire logic pclk, // system clock, 250 MHz
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high for write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data, registered
   output logic pready, // apb ready, always high
   output logic pslverr, // apb error for unmapped address
   output logic mem_rd_en, // read strobe to the macro
   output logic mem_rd_cfg, // read targets config space
   output logic mem_rd_prog, // read targets program flash
   output logic [`NVMC_ADDR_W-1:0] mem_rd_addr, // read word address
   input wire logic [`NVMC_DATA_W-1:0] mem_rdata, // read data, same cycle
   output nvmc_pkg::nvmc_mem_req_t mem_req, // program/erase step
   input wire logic mem_done, // step finished, one cycle
   output logic cpu_stall // hold the processor
);
   // all state of the block
   typedef struct packed {
      logic prog_sel; // program flash select
      logic cfg_sel; // config space select
      logic latch_only; // load latches only
      logic erase_sel; // erase on next write
      logic seq_err; // sequence error flag
      logic pe_enable; // program/erase enable
      logic write_ctl; // operation running
      logic read_ctl; // read pending
      logic [`NVMC_ADDR_W-1:0] addr; // address field
      logic [`NVMC_DATA_W-1:0] data; // data field
      nvmc_pkg::nvmc_ulk_t ulk; // unlock progress
      nvmc_pkg::nvmc_op_t op; // operation in progress
      logic [31:0] rdata; // apb read data
      logic slverr; // apb error
   } nvmc_state_t;

   nvmc_state_t s, next_s;

   // apb decode
   logic setup; // apb setup cycle
   logic access; // apb access completes this edge
   logic wr_ctrl; // control written this edge
   logic wr_unlock; // unlock written this edge
   logic mapped; // setup address hits a register
   logic [7:0] wbyte; // low write byte

   // space and window checks
   logic flash_space; // flash or config targeted
   logic cfg_wr_ok; // config write address allowed
   logic cfg_rd_ok; // config read address allowed

   // program/erase start
   logic start; // program/erase begins
   logic seq_busy; // sequencer running
   logic seq_done; // sequencer finished
   nvmc_pkg::nvmc_op_t op_kind; // operation chosen now
   nvmc_pkg::nvmc_mem_req_t seq_req; // request for the sequencer

   // register read path
   logic [7:0] ctrl_view; // control register as read
   logic [7:0] rd_mux; // selected register byte

   // a transfer commits at the edge that ends its access phase
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wbyte = pwdata[7:0];
   assign wr_ctrl = access && pwrite && (paddr == `NVMC_OFS_CONTROL);
   assign wr_unlock = access && pwrite && (paddr == `NVMC_OFS_UNLOCK);
   assign mapped = (paddr == `NVMC_OFS_CONTROL) || (paddr == `NVMC_OFS_UNLOCK)
      || (paddr == `NVMC_OFS_ADDR_LOW) || (paddr == `NVMC_OFS_ADDR_HIGH)
      || (paddr == `NVMC_OFS_DATA_LOW) || (paddr == `NVMC_OFS_DATA_HIGH);

   // eeprom only when both selects are clear
   assign flash_space = s.prog_sel || s.cfg_sel;

   // config space windows; id and config words are never written
   assign cfg_wr_ok = (s.addr <= `NVMC_CFG_USERID_LAST);
   assign cfg_rd_ok = (s.addr <= `NVMC_CFG_USERID_LAST) || (s.addr == `NVMC_CFG_DEVID)
      || ((s.addr >= `NVMC_CFG_WORD_FIRST) && (s.addr <= `NVMC_CFG_WORD_LAST));

   // operation kind from the selects at the moment of start
   always_comb begin
      if (!flash_space) begin
         op_kind = nvmc_pkg::NVMC_OP_EE_WRITE;
      end else if (s.erase_sel) begin
         op_kind = nvmc_pkg::NVMC_OP_ERASE;
      end else if (s.latch_only) begin
         op_kind = nvmc_pkg::NVMC_OP_LATCH;
      end else begin
         op_kind = nvmc_pkg::NVMC_OP_LATCH_PROG;
      end
   end

   // start only from idle, enabled, straight after the full pattern,
   // and never on a read-only config word
   assign start = wr_ctrl && wbyte[`NVMC_BIT_WRITE_CTL] && !s.write_ctl
      && s.pe_enable
      && (s.ulk == nvmc_pkg::NVMC_ULK_OPEN)
      && (!s.cfg_sel || cfg_wr_ok);

   always_comb begin
      seq_req.cmd = nvmc_pkg::NVMC_CMD_NONE;
      seq_req.cfg_space = s.cfg_sel;
      seq_req.prog_space = s.prog_sel;
      seq_req.addr = s.addr;
      seq_req.wdata = s.data;
   end

   // control register as software sees it
   assign ctrl_view = {s.prog_sel, s.cfg_sel, s.latch_only, s.erase_sel,
      s.seq_err, s.pe_enable, s.write_ctl, s.read_ctl};

   // read mux; unlock has no storage and reads zero
   always_comb begin
      case (paddr)
         `NVMC_OFS_CONTROL: rd_mux = ctrl_view;
         `NVMC_OFS_ADDR_LOW: rd_mux = s.addr[7:0];
         `NVMC_OFS_ADDR_HIGH: rd_mux = {1'b1, s.addr[14:8]};
         `NVMC_OFS_DATA_LOW: rd_mux = s.data[7:0];
         `NVMC_OFS_DATA_HIGH: rd_mux = {2'b00, s.data[13:8]};
         default: rd_mux = 8'h00;
      endcase
   end

   // next state: bus writes, unlock tracking, read port, completion
   always_comb begin
      next_s = s;
      // read data is sampled in setup so it leaves a flop in access
      if (setup) begin
         next_s.rdata = {24'h000000, rd_mux};
         next_s.slverr = !mapped;
      end
      // unlock pattern: any access other than the next step breaks it
      if (access) begin
         if (wr_unlock && (wbyte == `NVMC_UNLOCK_FIRST)) begin
            next_s.ulk = nvmc_pkg::NVMC_ULK_FIRST;
         end else if (wr_unlock && (wbyte == `NVMC_UNLOCK_SECOND)
               && (s.ulk == nvmc_pkg::NVMC_ULK_FIRST)) begin
            next_s.ulk = nvmc_pkg::NVMC_ULK_OPEN;
         end else begin
            next_s.ulk = nvmc_pkg::NVMC_ULK_LOCKED;
         end
      end
      // address and data writes; blocked while an operation runs
      if (access && pwrite && !s.write_ctl) begin
         case (paddr)
            `NVMC_OFS_ADDR_LOW: next_s.addr[7:0] = wbyte;
            `NVMC_OFS_ADDR_HIGH: next_s.addr[14:8] = wbyte[6:0];
            `NVMC_OFS_DATA_LOW: next_s.data[7:0] = wbyte;
            `NVMC_OFS_DATA_HIGH: next_s.data[13:8] = wbyte[5:0];
            default: ;
         endcase
      end
      // control writes; selects frozen while an operation runs
      if (wr_ctrl) begin
         next_s.pe_enable = wbyte[`NVMC_BIT_PE_ENABLE];
         next_s.seq_err = wbyte[`NVMC_BIT_SEQ_ERR];
         if (!s.write_ctl) begin
            next_s.prog_sel = wbyte[`NVMC_BIT_PROG_SEL];
            next_s.cfg_sel = wbyte[`NVMC_BIT_CFG_SEL];
            next_s.latch_only = wbyte[`NVMC_BIT_LATCH_ONLY];
            next_s.erase_sel = wbyte[`NVMC_BIT_ERASE_SEL];
            // read bit can only be set; ignored while writing
            if (wbyte[`NVMC_BIT_READ_CTL]) begin
               next_s.read_ctl = 1'b1;
            end
         end
      end
      // pending read: fetch word one cycle after the set
      if (s.read_ctl) begin
         next_s.read_ctl = 1'b0;
         if (s.cfg_sel && !cfg_rd_ok) begin
            next_s.data = `NVMC_RST_DATA;
         end else begin
            next_s.data = mem_rdata;
         end
      end
      // normal completion clears the flags the operation owns
      if (seq_done) begin
         next_s.write_ctl = 1'b0;
         next_s.seq_err = 1'b0;
         if (s.op == nvmc_pkg::NVMC_OP_ERASE) begin
            next_s.erase_sel = 1'b0;
         end
      end
      // start needs the write bit low, so it never meets a completion
      if (start) begin
         next_s.write_ctl = 1'b1;
         next_s.op = op_kind;
      end
      // any attempt to set the write bit raises the flag; set wins
      if (wr_ctrl && wbyte[`NVMC_BIT_WRITE_CTL]) begin
         next_s.seq_err = 1'b1;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   nvmc_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(start),
      .op(op_kind),
      .req_in(seq_req),
      .mem_done(mem_done),
      .mem_req(mem_req),
      .busy(seq_busy),
      .done(seq_done)
   );

   // apb answer: zero wait states, error shown in access only
   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = s.slverr && access;

   // read port straight from the register file
   assign mem_rd_en = s.read_ctl;
   assign mem_rd_cfg = s.cfg_sel;
   assign mem_rd_prog = s.prog_sel;
   assign mem_rd_addr = s.addr;

   // eeprom writes run in the background; flash and config hold the core
   assign cpu_stall = seq_busy && flash_space;

   // eeprom kind whenever both selects are clear at start
   property p_ee_kind;
      @(posedge pclk iff ce) disable iff (!presetn)
      start && !s.prog_sel && !s.cfg_sel |=> (s.op == nvmc_pkg::NVMC_OP_EE_WRITE) && s.write_ctl;
   endproperty
   a_ee_kind: assert property (p_ee_kind) else $error("eeprom op kind wrong");

   // erase completion drops the erase select
   property p_erase_clear;
      @(posedge pclk iff ce) disable iff (!presetn)
      seq_done && (s.op == nvmc_pkg::NVMC_OP_ERASE) |=> !s.erase_sel && !s.write_ctl;
   endproperty
   a_erase_clear: assert property (p_erase_clear) else $error("erase select not cleared");

   // attempt to set the write bit shows the error flag next cycle
   property p_err_on_attempt;
      @(posedge pclk iff ce) disable iff (!presetn)
      wr_ctrl && wbyte[`NVMC_BIT_WRITE_CTL] |=> s.seq_err;
   endproperty
   a_err_on_attempt: assert property (p_err_on_attempt) else $error("error flag not set");

   // nothing starts while program/erase is disabled
   property p_enable_gate;
      @(posedge pclk iff ce) disable iff (!presetn)
      $rose(s.write_ctl) |-> $past(s.pe_enable) && $past(wr_ctrl);
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("start while disabled");

   // write bit stays set until completion, then clears
   property p_write_hold;
      @(posedge pclk iff ce) disable iff (!presetn)
      s.write_ctl && !seq_done |=> s.write_ctl;
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("write bit dropped early");

   // read bit clears exactly one cycle after it is set
   property p_read_one;
      @(posedge pclk iff ce) disable iff (!presetn)
      $rose(s.read_ctl) |=> !s.read_ctl ##0 mem_rd_en == 1'b0;
   endproperty
   a_read_one: assert property (p_read_one) else $error("read bit not cleared");

   // start only straight after the complete pattern
   property p_unlock_before;
      @(posedge pclk iff ce) disable iff (!presetn)
      start |-> (s.ulk == nvmc_pkg::NVMC_ULK_OPEN) ##1 (s.ulk == nvmc_pkg::NVMC_ULK_LOCKED);
   endproperty
   a_unlock_before: assert property (p_unlock_before) else $error("start without unlock");

   // high address top bit reads one, upper bus bits read zero
   property p_read_fixed_bits;
      @(posedge pclk iff ce) disable iff (!presetn)
      setup && !pwrite && (paddr == `NVMC_OFS_ADDR_HIGH) |=> prdata[7] && (prdata[31:8] == 24'h000000);
   endproperty
   a_read_fixed_bits: assert property (p_read_fixed_bits) else $error("high address top bit");

   // stall only while a flash or config operation runs
   property p_stall;
      @(posedge pclk iff ce) disable iff (!presetn)
      cpu_stall |-> s.write_ctl && (s.op != nvmc_pkg::NVMC_OP_EE_WRITE);
   endproperty
   a_stall: assert property (p_stall) else $error("stall outside flash op");

   // a read outside the config windows leaves the data registers zero
   property p_cfg_hole_clear;
      @(posedge pclk iff ce) disable iff (!presetn)
      s.read_ctl && s.cfg_sel && !cfg_rd_ok |=> (s.data == `NVMC_RST_DATA);
   endproperty
   a_cfg_hole_clear: assert property (p_cfg_hole_clear) else $error("config hole not cleared");

   // no operation starts on a read-only config word
   property p_cfg_write_guard;
      @(posedge pclk iff ce) disable iff (!presetn)
      start && s.cfg_sel |-> (s.addr <= `NVMC_CFG_USERID_LAST);
   endproperty
   a_cfg_write_guard: assert property (p_cfg_write_guard) else $error("config word written");
endmodule
`default_nettype wire

/* verilog/nvmc_defines.svh */
// constants of the nonvolatile memory control block: offsets, bit positions,
// reset values and codes; included by the package and the design modules
`ifndef NVMC_DEFINES_SVH
`define NVMC_DEFINES_SVH

// widths of the memory address and the program word
`define NVMC_ADDR_W 15
`define NVMC_DATA_W 14

// apb byte offsets, one aligned word each
`define NVMC_OFS_CONTROL 8'h00
`define NVMC_OFS_UNLOCK 8'h04
`define NVMC_OFS_ADDR_LOW 8'h08
`define NVMC_OFS_ADDR_HIGH 8'h0c
`define NVMC_OFS_DATA_LOW 8'h10
`define NVMC_OFS_DATA_HIGH 8'h14

// control register bit positions
`define NVMC_BIT_PROG_SEL 7
`define NVMC_BIT_CFG_SEL 6
`define NVMC_BIT_LATCH_ONLY 5
`define NVMC_BIT_ERASE_SEL 4
`define NVMC_BIT_SEQ_ERR 3
`define NVMC_BIT_PE_ENABLE 2
`define NVMC_BIT_WRITE_CTL 1
`define NVMC_BIT_READ_CTL 0

// reset values
`define NVMC_RST_ADDR 15'h0000
`define NVMC_RST_DATA 14'h0000

// unlock pattern
`define NVMC_UNLOCK_FIRST 8'h55
`define NVMC_UNLOCK_SECOND 8'haa

// configuration space word addresses (space bit 15 implied)
`define NVMC_CFG_USERID_LAST 15'h0003
`define NVMC_CFG_DEVID 15'h0006
`define NVMC_CFG_WORD_FIRST 15'h0007
`define NVMC_CFG_WORD_LAST 15'h0008

`endif

/* verilog/nvmc_pkg.sv */
// types shared by the nonvolatile memory control block and its sequencer
// assumes nvmc_defines.svh is on the include path
`include "nvmc_defines.svh"
package nvmc_pkg;

   // one step that the memory macro carries out
   typedef enum logic [2:0] {
      NVMC_CMD_NONE,
      NVMC_CMD_LATCH,
      NVMC_CMD_PROGRAM,
      NVMC_CMD_ERASE,
      NVMC_CMD_EE_ERASE,
      NVMC_CMD_EE_WRITE
   } nvmc_cmd_t;

   // whole self-timed operation chosen at start
   typedef enum logic [1:0] {
      NVMC_OP_LATCH,
      NVMC_OP_LATCH_PROG,
      NVMC_OP_ERASE,
      NVMC_OP_EE_WRITE
   } nvmc_op_t;

   // progress through the unlock pattern
   typedef enum logic [1:0] {
      NVMC_ULK_LOCKED,
      NVMC_ULK_FIRST,
      NVMC_ULK_OPEN
   } nvmc_ulk_t;

   typedef enum logic [1:0] {
      NVMC_SEQ_IDLE,
      NVMC_SEQ_STEP1,
      NVMC_SEQ_STEP2
   } nvmc_seq_st_t;

   // request handed to the memory macro
   typedef struct packed {
      nvmc_cmd_t cmd;
      logic cfg_space;
      logic prog_space;
      logic [`NVMC_ADDR_W-1:0] addr;
      logic [`NVMC_DATA_W-1:0] wdata;
   } nvmc_mem_req_t;

endpackage

/* verilog/nvmc_seq.sv */
// step sequencer: walks a self-timed operation through its memory steps
// assumes the macro answers each held step with a one-cycle mem_done
`timescale 1ns/10ps
`default_nettype none
`include "nvmc_defines.svh"
module nvmc_seq (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic start, // begin an operation, one cycle
   input wire nvmc_pkg::nvmc_op_t op, // operation kind at start
   input wire nvmc_pkg::nvmc_mem_req_t req_in, // space, address, data at start
   input wire logic mem_done, // macro finished the current step
   output nvmc_pkg::nvmc_mem_req_t mem_req, // step held to the macro
   output logic busy, // operation in progress
   output logic done // operation complete, one cycle
);
   typedef struct packed {
      nvmc_pkg::nvmc_seq_st_t st;
      nvmc_pkg::nvmc_op_t op;
      nvmc_pkg::nvmc_mem_req_t req;
      logic done;
   } nvmc_seq_state_t;

   nvmc_seq_state_t s, next_s;

   // first memory step of each operation
   function automatic nvmc_pkg::nvmc_cmd_t first_cmd(input nvmc_pkg::nvmc_op_t o);
      case (o)
         nvmc_pkg::NVMC_OP_ERASE: first_cmd = nvmc_pkg::NVMC_CMD_ERASE;
         nvmc_pkg::NVMC_OP_EE_WRITE: first_cmd = nvmc_pkg::NVMC_CMD_EE_ERASE;
         default: first_cmd = nvmc_pkg::NVMC_CMD_LATCH;
      endcase
   endfunction

   // step order; two-step kinds chain a second step on the first done
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      case (s.st)
         nvmc_pkg::NVMC_SEQ_IDLE: begin
            if (start) begin
               next_s.op = op;
               next_s.req = req_in;
               next_s.req.cmd = first_cmd(op);
               next_s.st = nvmc_pkg::NVMC_SEQ_STEP1;
            end
         end
         nvmc_pkg::NVMC_SEQ_STEP1: begin
            if (mem_done) begin
               if (s.op == nvmc_pkg::NVMC_OP_LATCH_PROG) begin
                  next_s.req.cmd = nvmc_pkg::NVMC_CMD_PROGRAM;
                  next_s.st = nvmc_pkg::NVMC_SEQ_STEP2;
               end else if (s.op == nvmc_pkg::NVMC_OP_EE_WRITE) begin
                  next_s.req.cmd = nvmc_pkg::NVMC_CMD_EE_WRITE;
                  next_s.st = nvmc_pkg::NVMC_SEQ_STEP2;
               end else begin
                  next_s.req.cmd = nvmc_pkg::NVMC_CMD_NONE;
                  next_s.st = nvmc_pkg::NVMC_SEQ_IDLE;
                  next_s.done = 1'b1;
               end
            end
         end
         nvmc_pkg::NVMC_SEQ_STEP2: begin
            if (mem_done) begin
               next_s.req.cmd = nvmc_pkg::NVMC_CMD_NONE;
               next_s.st = nvmc_pkg::NVMC_SEQ_IDLE;
               next_s.done = 1'b1;
            end
         end
         default: next_s.st = nvmc_pkg::NVMC_SEQ_IDLE;
      endcase
   end

   // state register, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign mem_req = s.req;
   assign busy = (s.st != nvmc_pkg::NVMC_SEQ_IDLE);
   assign done = s.done;

   // latch-only load never reaches a programming step
   property p_latch_only_no_prog;
      @(posedge pclk iff ce) disable iff (!presetn)
      (s.op == nvmc_pkg::NVMC_OP_LATCH) && busy |-> (mem_req.cmd != nvmc_pkg::NVMC_CMD_PROGRAM);
   endproperty
   a_latch_only_no_prog: assert property (p_latch_only_no_prog) else $error("latch-only programmed");

   // eeprom write: erase step answered leads to the write step
   property p_ee_erase_then_write;
      @(posedge pclk iff ce) disable iff (!presetn)
      (mem_req.cmd == nvmc_pkg::NVMC_CMD_EE_ERASE) && mem_done
         |=> (mem_req.cmd == nvmc_pkg::NVMC_CMD_EE_WRITE) && busy;
   endproperty
   a_ee_erase_then_write: assert property (p_ee_erase_then_write) else $error("no write after erase");
endmodule
`default_nettype wire
